// file: rtl/chbp_device_port.sv
// Purpose: Slave host-bus port of the security coprocessor.
// Assumes: Host drives pins synchronously to clk; straps static out of reset.
// Notes: Units behind the port are reached through the user-side ports.
// Notes on behaviour
// - Decode 12-bit address into per-unit selects.
// - 32-bit data, bit 0 is most significant.
// - Respond only while unit select low.
// - Read/write high reads, low writes.
// - Burst low marks a burst access, in pipelined mode only.
// - Simple mode starts on cycle-begin strobe.
// - Beat-valid ignored while bus strap is 0.
// - Beat-valid low captures or completes a beat.
// - Simple mode acknowledges completion by driving low.
// - Pipelined mode drives the pin as wait.
// - Asynchronous reset forces a known state.
// - System lets software drive the reset too.
// - Strap 1 pipelined, strap 0 simple.
// - Byte-order strap high big, low little.
// - Interrupt low while any unit enabled in irqMask interrupts.
// - DMA requests active high on buffer need.
// - Each DMA request selects input or output buffer.
// - Masked unit interrupts ORed, no priority.
`timescale 1ns/1ns
module chbp_device_port
    import chbp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    chbp_if.device bus,
    output logic [UNIT_COUNT-1:0] unitSelect,
    output logic [ADDR_W-1:0] unitAddr,
    output logic [DATA_W-1:0] unitWriteData,
    output logic unitWrite,
    output logic unitRead,
    output logic unitBurst,
    input wire logic [DATA_W-1:0] unitReadData,
    input wire logic [UNIT_COUNT-1:0] unitIrq,
    input wire logic [UNIT_COUNT-1:0] irqMask,
    input wire logic inputBufferNeed,
    input wire logic outputBufferNeed,
    input wire logic dmaOneUsesOutput,
    input wire logic dmaTwoUsesOutput
);
    chbp_state_t state;
    chbp_state_t next_state;
    logic [1:0] waitCount;
    logic isRead;
    logic [DATA_W-1:0] readHold;
    logic [ADDR_W-1:0] addrMsb0;
    logic [DATA_W-1:0] dataMsb0;
    logic [DATA_W-1:0] dataOrdered;
    logic startCycle;
    logic beatOk;
    logic [DATA_W-1:0] readOrdered;

    // Pin bit 0 is the most significant bit; flip to the usual internal order.
    always_comb begin
        for (int i = 0; i < ADDR_W; i++) begin
            addrMsb0[i] = bus.addr[ADDR_W-1-i];
        end
        for (int i = 0; i < DATA_W; i++) begin
            dataMsb0[i] = bus.dataBus[DATA_W-1-i];
        end
    end

    // Little-endian mode swaps the bytes; big-endian passes words unchanged.
    function automatic logic [DATA_W-1:0] order_bytes(input logic [DATA_W-1:0] w,
                                                      input logic big);
        order_bytes = big ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    assign dataOrdered = order_bytes(dataMsb0, bus.byteOrder);
    assign readOrdered = order_bytes(unitReadData, bus.byteOrder);

    // A cycle opens only while selected; the strobe matters only in simple mode.
    assign startCycle = !bus.unitSelect_n &&
        (bus.busFlavour || !bus.cycle_begin_strobe_n);
    // Beat-valid is gated by the strap so a floating pin in simple mode is harmless.
    assign beatOk = !bus.busFlavour || !bus.beat_valid_n;

    // Transfer sequencer.
    always_comb begin
        next_state = state;
        unique case (state)
            CHBP_IDLE: begin
                if (startCycle) begin
                    next_state = CHBP_WAIT;
                end
            end
            CHBP_WAIT: begin
                if (waitCount == 2'(WAIT_CYCLES - 1) && beatOk) begin
                    next_state = CHBP_DONE;
                end
            end
            CHBP_DONE: begin
                next_state = CHBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= CHBP_IDLE;
        end else if (clkEnable) begin
            state <= next_state;
        end
    end

    // Wait-state counter; gives units time to produce read data.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCount <= WAIT_RESET;
        end else if (clkEnable) begin
            if (state != CHBP_WAIT) begin
                waitCount <= WAIT_RESET;
            end else if (waitCount != 2'(WAIT_CYCLES - 1)) begin
                waitCount <= waitCount + 2'h1;
            end
        end
    end

    // Capture address, direction and burst at cycle start.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unitAddr <= ADDR_RESET;
            unitSelect <= '0;
            isRead <= 1'b0;
            unitBurst <= 1'b0;
        end else if (clkEnable) begin
            if (state == CHBP_IDLE && startCycle) begin
                unitAddr <= addrMsb0;
                isRead <= bus.readNotWrite;
                unitBurst <= bus.busFlavour && !bus.burst_n;
                unitSelect <= '0;
                unique case (addrMsb0[ADDR_W-1 -: 4])
                    UNIT_DIGEST: unitSelect[SEL_DIGEST] <= 1'b1;
                    UNIT_BLOCK: unitSelect[SEL_BLOCK] <= 1'b1;
                    UNIT_STREAM: unitSelect[SEL_STREAM] <= 1'b1;
                    UNIT_RANDOM: unitSelect[SEL_RANDOM] <= 1'b1;
                    UNIT_PUBKEY, UNIT_BUF_PAGE: begin
                        // These pages share units; in page b, internal address bit 7 splits them.
                        if (addrMsb0[ADDR_W-1 -: 4] == UNIT_BUF_PAGE &&
                            addrMsb0[UNIT_SPLIT_BIT]) begin
                            unitSelect[SEL_BUF] <= 1'b1;
                        end else begin
                            unitSelect[SEL_PUBKEY] <= 1'b1;
                        end
                    end
                    default: unitSelect <= '0;
                endcase
            end else if (state == CHBP_DONE) begin
                unitSelect <= '0;
            end
        end
    end

    // Write strobe and data go out as the beat completes.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unitWrite <= 1'b0;
            unitRead <= 1'b0;
            unitWriteData <= DATA_RESET;
        end else if (clkEnable) begin
            unitWrite <= state == CHBP_WAIT && next_state == CHBP_DONE && !isRead;
            unitRead <= state == CHBP_IDLE && startCycle && bus.readNotWrite;
            if (state == CHBP_WAIT && next_state == CHBP_DONE && !isRead) begin
                unitWriteData <= dataOrdered;
            end
        end
    end

    // Read data is held in a flop and driven only during the selected read.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readHold <= DATA_RESET;
            bus.devDataOe <= 1'b0;
        end else if (clkEnable) begin
            if (state == CHBP_WAIT && isRead) begin
                for (int i = 0; i < DATA_W; i++) begin
                    readHold[i] <= readOrdered[DATA_W-1-i];
                end
            end
            bus.devDataOe <= isRead && !bus.unitSelect_n && next_state == CHBP_DONE;
        end
    end
    assign bus.devDataOut = readHold;

    // One pin, two meanings: acknowledge low in simple mode, wait high in pipelined.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus.xfer_done_n <= 1'b1;
        end else if (clkEnable) begin
            if (bus.busFlavour) begin
                bus.xfer_done_n <= next_state == CHBP_WAIT ||
                    (state == CHBP_IDLE && startCycle);
            end else begin
                bus.xfer_done_n <= !(next_state == CHBP_DONE);
            end
        end
    end

    // Interrupt and DMA pins; combinational so that unit events show at once.
    assign bus.interrupt_n = !(|(unitIrq & irqMask));
    assign bus.dma_request_one = dmaOneUsesOutput ? outputBufferNeed : inputBufferNeed;
    assign bus.dma_request_two = dmaTwoUsesOutput ? outputBufferNeed : inputBufferNeed;
endmodule

// file: shared/chbp_pkg.sv
// Purpose: Shared constants and types for the coprocessor host bus port.
// Assumes: One 20 MHz clock; asynchronous active-low reset.
// Notes: Bit 0 of address and data is the most significant bit on the pins.
package chbp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int UNIT_COUNT = 6;
    localparam int WAIT_CYCLES = 2;
    localparam logic [1:0] WAIT_RESET = 2'h0;
    // Unit select decode uses the top four address bits (pin order bit 0..3).
    localparam logic [3:0] UNIT_DIGEST = 4'h0;
    localparam logic [3:0] UNIT_BLOCK = 4'h2;
    localparam logic [3:0] UNIT_STREAM = 4'h4;
    localparam logic [3:0] UNIT_RANDOM = 4'h6;
    localparam logic [3:0] UNIT_PUBKEY = 4'ha;
    localparam logic [3:0] UNIT_BUF_PAGE = 4'hb;
    // Internal address bit that splits the shared page between its two units.
    localparam int UNIT_SPLIT_BIT = 7;
    localparam int SEL_DIGEST = 0;
    localparam int SEL_BLOCK = 1;
    localparam int SEL_STREAM = 2;
    localparam int SEL_RANDOM = 3;
    localparam int SEL_PUBKEY = 4;
    localparam int SEL_BUF = 5;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h0;
    // Port state machine states, one-hot.
    typedef enum logic [2:0] {
        CHBP_IDLE = 3'h1,
        CHBP_WAIT = 3'h2,
        CHBP_DONE = 3'h4
    } chbp_state_t;
    // Host state machine states, one-hot.
    typedef enum logic [2:0] {
        CHBP_H_IDLE = 3'h1,
        CHBP_H_BUSY = 3'h2,
        CHBP_H_END = 3'h4
    } chbp_hstate_t;
endpackage

// file: shared/chbp_if.sv
// Purpose: Pin-level link between the host and the coprocessor port.
// Assumes: Both ends on clk; data wire resolved from the two enables.
// Notes: The resolved wire is exposed as dataBus for both ends.
`timescale 1ns/1ns
interface chbp_if;
    import chbp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] hostDataOut;
    logic hostDataOe;
    logic [DATA_W-1:0] devDataOut;
    logic devDataOe;
    logic [DATA_W-1:0] dataBus;
    logic unitSelect_n;
    logic readNotWrite;
    logic burst_n;
    logic cycle_begin_strobe_n;
    logic beat_valid_n;
    logic xfer_done_n;
    logic interrupt_n;
    logic dma_request_one;
    logic dma_request_two;
    logic busFlavour;
    logic byteOrder;

    // Wire resolution; an undriven bus floats high through the pull-up model.
    assign dataBus = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : '1);

    modport device (
        input addr, dataBus, unitSelect_n, readNotWrite, burst_n,
        input cycle_begin_strobe_n, beat_valid_n, busFlavour, byteOrder,
        output devDataOut, devDataOe, xfer_done_n, interrupt_n,
        output dma_request_one, dma_request_two
    );
    modport host (
        input dataBus, xfer_done_n, interrupt_n, dma_request_one, dma_request_two,
        output addr, hostDataOut, hostDataOe, unitSelect_n, readNotWrite,
        output burst_n, cycle_begin_strobe_n, beat_valid_n, busFlavour, byteOrder
    );
endinterface

// file: rtl/chbp_host_end.sv
// Purpose: Host end that runs single transfers on the coprocessor port.
// Assumes: User raises reqValid for one cycle while idle.
// Notes: Straps come from user ports and must change only under reset.
`timescale 1ns/1ns
module chbp_host_end
    import chbp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    chbp_if.host bus,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic reqBurst,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqData,
    input wire logic pipelinedMode,
    input wire logic bigEndian,
    output logic reqReady,
    output logic respValid,
    output logic [DATA_W-1:0] respData,
    output logic deviceIrq,
    output logic dmaOne,
    output logic dmaTwo
);
    chbp_hstate_t state;
    logic ackSeen;
    logic busyStarted;

    // Straps pass straight through; holding them is the system's duty.
    assign bus.busFlavour = pipelinedMode;
    assign bus.byteOrder = bigEndian;
    assign reqReady = state == CHBP_H_IDLE;
    // Both meanings of the pin read low as done: acknowledge, or wait released.
    assign ackSeen = !bus.xfer_done_n;

    // The first busy edge still sees the idle level of the done pin, which in
    // pipelined mode is low and would pass for a finished wait.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busyStarted <= 1'b0;
        end else if (clkEnable) begin
            busyStarted <= state == CHBP_H_BUSY;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= CHBP_H_IDLE;
            bus.addr <= ADDR_RESET;
            bus.hostDataOut <= DATA_RESET;
            bus.hostDataOe <= 1'b0;
            bus.unitSelect_n <= 1'b1;
            bus.readNotWrite <= 1'b1;
            bus.burst_n <= 1'b1;
            bus.cycle_begin_strobe_n <= 1'b1;
            bus.beat_valid_n <= 1'b1;
            respValid <= 1'b0;
            respData <= DATA_RESET;
        end else if (clkEnable) begin
            respValid <= 1'b0;
            bus.cycle_begin_strobe_n <= 1'b1;
            unique case (state)
                CHBP_H_IDLE: begin
                    if (reqValid) begin
                        for (int i = 0; i < ADDR_W; i++) begin
                            bus.addr[i] <= reqAddr[ADDR_W-1-i];
                        end
                        for (int i = 0; i < DATA_W; i++) begin
                            bus.hostDataOut[i] <= reqData[DATA_W-1-i];
                        end
                        bus.hostDataOe <= !reqRead;
                        bus.unitSelect_n <= 1'b0;
                        bus.readNotWrite <= reqRead;
                        bus.burst_n <= !(pipelinedMode && reqBurst);
                        bus.cycle_begin_strobe_n <= pipelinedMode;
                        bus.beat_valid_n <= !pipelinedMode;
                        state <= CHBP_H_BUSY;
                    end
                end
                CHBP_H_BUSY: begin
                    // Read data stand only in the done cycle, so take them on that edge,
                    // and drop the select at once so the port cannot start again.
                    if (busyStarted && ackSeen) begin
                        for (int i = 0; i < DATA_W; i++) begin
                            respData[i] <= bus.dataBus[DATA_W-1-i];
                        end
                        bus.unitSelect_n <= 1'b1;
                        bus.hostDataOe <= 1'b0;
                        bus.beat_valid_n <= 1'b1;
                        bus.burst_n <= 1'b1;
                        state <= CHBP_H_END;
                    end
                end
                CHBP_H_END: begin
                    respValid <= 1'b1;
                    state <= CHBP_H_IDLE;
                end
                default: state <= CHBP_H_IDLE;
            endcase
        end
    end

    assign deviceIrq = !bus.interrupt_n;
    assign dmaOne = bus.dma_request_one;
    assign dmaTwo = bus.dma_request_two;
endmodule

// file: dv/chbp_sva.sv
// Purpose: Pin checks between the host end and the coprocessor port.
// Assumes: One clock; reset_n asynchronous and active low.
// Notes: Straps are static between resets, so they may qualify each check.
`timescale 1ns/1ns
module chbp_sva
    import chbp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic devDataOe,
    input wire logic unitSelect_n,
    input wire logic readNotWrite,
    input wire logic cycle_begin_strobe_n,
    input wire logic xfer_done_n,
    input wire logic busFlavour
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // The port owns the data lines only for a selected read.
    a_oe_needs_select: assert property (devDataOe |-> !unitSelect_n)
        else $error("data driven while unselected");
    a_oe_read_only: assert property (devDataOe |-> readNotWrite)
        else $error("data driven during a write");
    // Simple mode: the acknowledge follows the start strobe after the wait states.
    a_ack_latency: assert property (
        !busFlavour && $fell(cycle_begin_strobe_n) && !unitSelect_n
        |-> xfer_done_n [*3] ##[1:2] !xfer_done_n)
        else $error("acknowledge late or early");
    a_ack_cause: assert property (!busFlavour && !xfer_done_n |->
        (!$past(cycle_begin_strobe_n, 3) || !$past(cycle_begin_strobe_n, 4)))
        else $error("acknowledge without a start");
    a_ack_one_cycle: assert property (!busFlavour && !xfer_done_n |=> xfer_done_n)
        else $error("acknowledge longer than one cycle");
    // A simple read drives data exactly in its acknowledge cycle.
    a_read_data_ack: assert property (
        !busFlavour && readNotWrite && !unitSelect_n |-> (devDataOe == !xfer_done_n))
        else $error("read data not aligned with acknowledge");
    // Pipelined mode: wait goes high after select, then drops within a bound.
    a_wait_after_sel: assert property (
        busFlavour && $fell(unitSelect_n) |=> xfer_done_n)
        else $error("no wait state after select");
    a_wait_ends: assert property (
        busFlavour && $fell(unitSelect_n) |-> ##[1:8] !xfer_done_n)
        else $error("wait never released");
    c_simple_read: cover property (!busFlavour && !xfer_done_n && readNotWrite);
    c_simple_write: cover property (!busFlavour && !xfer_done_n && !readNotWrite);
    c_pipe_start: cover property (busFlavour && $fell(unitSelect_n));
endmodule

// file: dv/crypto_coproc_host_bus_port_tb.sv
// Purpose: Bench joining the host end and the coprocessor port back to back.
// Assumes: Straps change only while reset is held.
// Notes: Every strap pair reruns the same address table.
`timescale 1ns/1ns
module crypto_coproc_host_bus_port_tb;
    import chbp_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqRead = 1'b0, reqBurst = 1'b0;
    logic pipelinedMode = 1'b0, bigEndian = 1'b1, reqReady, respValid, deviceIrq;
    logic dmaOne, dmaTwo, unitWrite, unitRead, unitBurst, capBurst;
    logic inNeed = 1'b0, outNeed = 1'b0, oneOut = 1'b0, twoOut = 1'b0;
    logic [ADDR_W-1:0] reqAddr = '0, unitAddr, capAddr;
    logic [DATA_W-1:0] reqData = '0, respData, unitWriteData, unitReadData = '0, capData;
    logic [UNIT_COUNT-1:0] unitSelect, capSel, unitIrq = '0, irqMask = '0;
    int numErrors = 0, samplesChecked = 0, accesses = 0;
    logic [ADDR_W-1:0] addrTab [7] = '{12'h015, 12'h201, 12'h400, 12'h600, 12'ha40,
        12'hb01, 12'hb80};
    int selTab [7] = '{0, 1, 2, 3, 4, 4, 5};
    chbp_if bus ();
    chbp_device_port u_chbp_device_port (.clk(clk), .reset_n(reset_n), .clkEnable(1'b1),
        .bus(bus), .unitSelect(unitSelect), .unitAddr(unitAddr),
        .unitWriteData(unitWriteData), .unitWrite(unitWrite), .unitRead(unitRead),
        .unitBurst(unitBurst), .unitReadData(unitReadData), .unitIrq(unitIrq),
        .irqMask(irqMask), .inputBufferNeed(inNeed), .outputBufferNeed(outNeed),
        .dmaOneUsesOutput(oneOut), .dmaTwoUsesOutput(twoOut));
    chbp_host_end u_chbp_host_end (.clk(clk), .reset_n(reset_n), .clkEnable(1'b1),
        .bus(bus), .reqValid(reqValid), .reqRead(reqRead), .reqBurst(reqBurst),
        .reqAddr(reqAddr), .reqData(reqData), .pipelinedMode(pipelinedMode),
        .bigEndian(bigEndian), .reqReady(reqReady), .respValid(respValid),
        .respData(respData), .deviceIrq(deviceIrq), .dmaOne(dmaOne), .dmaTwo(dmaTwo));
    chbp_sva u_chbp_sva (.clk(clk), .reset_n(reset_n), .devDataOe(bus.devDataOe),
        .unitSelect_n(bus.unitSelect_n), .readNotWrite(bus.readNotWrite),
        .cycle_begin_strobe_n(bus.cycle_begin_strobe_n), .xfer_done_n(bus.xfer_done_n),
        .busFlavour(bus.busFlavour));
    // Free-running 20 MHz clock.
    always #25 clk = ~clk;
    // Record what the port hands its units, so each access is judged after it ends.
    always @(posedge clk) begin
        if (unitWrite || unitRead) begin
            capSel <= unitSelect;
            capAddr <= unitAddr;
            capBurst <= unitBurst;
            accesses <= accesses + 1;
        end
        if (unitWrite) begin
            capData <= unitWriteData;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic printVerdict();
        if (numErrors == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Little-endian mode swaps the bytes of every word.
    function automatic logic [31:0] swapOrder(input logic [31:0] w, input logic big);
        return big ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    // Straps move only while reset is low.
    task automatic doReset(input logic pm, input logic be);
        reset_n <= 1'b0;
        @(posedge clk);
        pipelinedMode <= pm;
        bigEndian <= be;
        repeat (5) @(posedge clk);
        check({30'h0, bus.devDataOe, bus.xfer_done_n}, 32'h1);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic xfer(input logic rd, input logic bst, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] resp);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        reqValid <= 1'b1;
        reqRead <= rd;
        reqBurst <= bst;
        reqAddr <= a;
        reqData <= d;
        @(posedge clk);
        reqValid <= 1'b0;
        n = 0;
        while (respValid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        resp = respData;
        check(32'(n < 50), 32'h1);
        repeat (3) @(posedge clk);
    endtask
    // Main sequence: every strap pair, then interrupt and request lines, then a reset.
    initial begin
        logic [31:0] d, r;
        int n;
        for (int m = 0; m < 4; m++) begin
            doReset(m[1], m[0]);
            for (int i = 0; i < 7; i++) begin
                d = {addrTab[i], 8'ha5, ~addrTab[i]};
                n = accesses;
                xfer(1'b0, i[0], addrTab[i], d, r);
                check(capData, swapOrder(d, m[0]));
                check(32'(capSel), 32'h1 << selTab[i]);
                check(32'(capAddr), 32'(addrTab[i]));
                check(32'(capBurst), 32'(m[1] & i[0]));
                unitReadData <= ~d;
                xfer(1'b1, i[0], addrTab[i], d, r);
                check(r, swapOrder(~d, m[0]));
                check(32'(accesses - n), 32'h2);
            end
        end
        for (int k = 0; k < 64; k++) begin
            unitIrq <= 6'(k);
            irqMask <= 6'(k * 5);
            {oneOut, twoOut, inNeed, outNeed} <= 4'(k * 3);
            @(posedge clk);
            check(32'(deviceIrq), 32'(|(unitIrq & irqMask)));
            check(32'(bus.interrupt_n), 32'(~|(unitIrq & irqMask)));
            check({30'h0, dmaTwo, dmaOne}, {30'h0, twoOut ? outNeed : inNeed,
                oneOut ? outNeed : inNeed});
        end
        reqValid <= 1'b1;
        reqRead <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b0;
        #1;
        check({30'h0, bus.devDataOe, bus.xfer_done_n}, 32'h1);
        doReset(1'b0, 1'b1);
        // The port must come back clean from a reset that cut a transfer short.
        unitReadData <= 32'h1234abcd;
        xfer(1'b1, 1'b0, 12'h600, 32'h0, r);
        check(r, 32'h1234abcd);
        printVerdict();
    end
    // A hung handshake still ends the run with a verdict.
    initial begin
        repeat (6000) @(posedge clk);
        check(32'h0, 32'h1);
        printVerdict();
    end
endmodule
